// *** core/hsc_decode.sv ***
/*
 * decodes the hardware control mode strap pins of a dual channel line interface
 * into per channel and global control settings.
 * assumes the straps are static levels from the board, asynchronous to clock_in.
 */
`timescale 1ns/100ps
`include "hsc_defines.svh"
module hsc_decode (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] tx_pattern_select_in,
    input wire logic [1:0] jitter_atten_select_in,
    input wire logic [1:0] rx_monitor_gain_select_in,
    input wire logic [3:0] loopback_select_in,
    input wire logic tx_driver_hiz_in,
    input wire logic rx_clock_edge_select_in,
    input wire logic [1:0] rx_power_down_in,
    output hsc_pkg::hsc_tx_pattern_e tx_pattern_ch0_out,
    output hsc_pkg::hsc_tx_pattern_e tx_pattern_ch1_out,
    output logic [1:0] tx_send_normal_out,
    output logic [1:0] tx_send_ones_out,
    output logic [1:0] tx_send_prbs_out,
    output logic [1:0] tx_power_down_out,
    output hsc_pkg::hsc_ja_mode_e ja_mode_out,
    output logic ja_enable_out,
    output logic ja_in_rx_out,
    output logic ja_in_tx_out,
    output logic ja_narrow_bw_out,
    output logic [7:0] ja_fifo_depth_out,
    output logic [9:0] rx_monitor_gain_db_out,
    output hsc_pkg::hsc_loopback_e loopback_ch0_out,
    output hsc_pkg::hsc_loopback_e loopback_ch1_out,
    output logic [1:0] lb_analog_out,
    output logic [1:0] lb_digital_out,
    output logic [1:0] lb_remote_out,
    output logic [1:0] lb_inband_out,
    output logic [1:0] tx_driver_enable_out,
    output logic rx_clock_falling_out,
    output logic [1:0] rx_power_down_out
);
    import hsc_pkg::*;

    localparam int NRAW = 16;
    logic [NRAW-1:0] raw_bus;
    logic [NRAW-1:0] clean;
    logic [3:0] patt_s;
    logic [1:0] ja_s;
    logic [1:0] gain_s;
    logic [3:0] lp_s;
    logic hiz_s;
    logic edge_s;
    logic [1:0] rpd_s;

    // gather every strap for synchronisation
    assign raw_bus = {tx_pattern_select_in, jitter_atten_select_in, rx_monitor_gain_select_in,
                      loopback_select_in, tx_driver_hiz_in, rx_clock_edge_select_in, rx_power_down_in};

    // one synchroniser per strap bit; bits of one code settle on their own,
    // so a code that moves may show a mixed value for a cycle before it lands
    genvar gi;
    generate
        for (gi = 0; gi < NRAW; gi++) begin : g_sync
            hsc_sync_if sif ();
            assign sif.raw = raw_bus[gi];
            hsc_sync u_sync (
                .clock_in(clock_in),
                .sys_rst_in(sys_rst_in),
                .port_in(sif)
            );
            assign clean[gi] = sif.clean;
        end
    endgenerate

    // split the synchronised levels back into fields
    // field order matches the gather above, most significant first
    assign {patt_s, ja_s, gain_s, lp_s, hiz_s, edge_s, rpd_s} = clean;

    // per channel pattern and loopback decode
    generate
        for (gi = 0; gi < `HSC_NUM_CH; gi++) begin : g_ch
            // one-hot pattern flags for this channel
            always_ff @(posedge clock_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    tx_send_normal_out[gi] <= 1'b1;
                    tx_send_ones_out[gi] <= 1'b0;
                    tx_send_prbs_out[gi] <= 1'b0;
                    tx_power_down_out[gi] <= 1'b0;
                end else begin
                    tx_send_normal_out[gi] <= (patt_s[2*gi +: 2] == `HSC_PATT_NORMAL);
                    tx_send_ones_out[gi] <= (patt_s[2*gi +: 2] == `HSC_PATT_ONES);
                    tx_send_prbs_out[gi] <= (patt_s[2*gi +: 2] == `HSC_PATT_PRBS);
                    tx_power_down_out[gi] <= (patt_s[2*gi +: 2] == `HSC_PATT_PDN);
                end
            end
            // one-hot loopback flags for this channel
            always_ff @(posedge clock_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    lb_analog_out[gi] <= 1'b0;
                    lb_digital_out[gi] <= 1'b0;
                    lb_remote_out[gi] <= 1'b0;
                end else begin
                    lb_analog_out[gi] <= (lp_s[2*gi +: 2] == `HSC_LP_ANALOG);
                    lb_digital_out[gi] <= (lp_s[2*gi +: 2] == `HSC_LP_DIGITAL);
                    lb_remote_out[gi] <= (lp_s[2*gi +: 2] == `HSC_LP_REMOTE);
                end
            end
            // monitor gain per receiver in dB
            always_ff @(posedge clock_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    rx_monitor_gain_db_out[5*gi +: 5] <= `HSC_GAIN_LOW_DB;
                end else begin
                    rx_monitor_gain_db_out[5*gi +: 5] <= gain_s[gi] ? `HSC_GAIN_HIGH_DB : `HSC_GAIN_LOW_DB;
                end
            end
        end
    endgenerate

    // pattern code as an enumerated view per channel
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_pattern_ch0_out <= HSC_TXP_NORMAL;
            tx_pattern_ch1_out <= HSC_TXP_NORMAL;
        end else begin
            tx_pattern_ch0_out <= hsc_tx_pattern_e'(patt_s[1:0]);
            tx_pattern_ch1_out <= hsc_tx_pattern_e'(patt_s[3:2]);
        end
    end

    // loopback code as an enumerated view per channel
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            loopback_ch0_out <= HSC_LB_NONE;
            loopback_ch1_out <= HSC_LB_NONE;
        end else begin
            loopback_ch0_out <= hsc_loopback_e'(lp_s[1:0]);
            loopback_ch1_out <= hsc_loopback_e'(lp_s[3:2]);
        end
    end

    // in-band loopback is never reachable from straps: code 11 means remote,
    // so the in-band request stays low whatever the straps say
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            lb_inband_out <= 2'h0;
        end else begin
            lb_inband_out <= 2'h0;
        end
    end

    // attenuator code as an enumerated view
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ja_mode_out <= HSC_JA_DISABLED;
        end else begin
            ja_mode_out <= hsc_ja_mode_e'(ja_s);
        end
    end

    // attenuator placement: off, receive path or transmit path
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ja_enable_out <= 1'b0;
            ja_in_rx_out <= 1'b0;
            ja_in_tx_out <= 1'b0;
        end else begin
            ja_enable_out <= (ja_s != `HSC_JA_OFF);
            ja_in_rx_out <= (ja_s == `HSC_JA_RX_BROAD) || (ja_s == `HSC_JA_RX_NARROW);
            ja_in_tx_out <= (ja_s == `HSC_JA_TX);
        end
    end

    // attenuator bandwidth and fifo depth; both only matter in the receive path
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ja_narrow_bw_out <= 1'b0;
            ja_fifo_depth_out <= `HSC_FIFO_DEPTH_NONE;
        end else begin
            ja_narrow_bw_out <= (ja_s == `HSC_JA_RX_NARROW);
            case (ja_s)
                `HSC_JA_RX_BROAD: ja_fifo_depth_out <= `HSC_FIFO_DEPTH_BROAD;
                `HSC_JA_RX_NARROW: ja_fifo_depth_out <= `HSC_FIFO_DEPTH_NARROW;
                default: ja_fifo_depth_out <= `HSC_FIFO_DEPTH_NONE;
            endcase
        end
    end

    // both line drivers follow the one high-impedance strap; they stay off
    // through reset, then turn on for two edges from the cleared synchronisers before the strap level arrives
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_driver_enable_out <= 2'h0;
        end else begin
            tx_driver_enable_out <= {2{~hiz_s}};
        end
    end

    // active edge of both recovered receive clocks
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_clock_falling_out <= 1'b0;
        end else begin
            rx_clock_falling_out <= edge_s;
        end
    end

    // receiver power down, one bit per channel
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_power_down_out <= 2'h0;
        end else begin
            rx_power_down_out <= rpd_s;
        end
    end
endmodule : hsc_decode

// *** core/hsc_defines.svh ***
/*
 * constants for the hardware strap configuration decoder: codes, fifo depths, gain values, channel and stage counts.
 * assumes inclusion by bare name from core files.
 */
`ifndef HSC_DEFINES_SVH
`define HSC_DEFINES_SVH
`define HSC_NUM_CH 2
`define HSC_PATT_NORMAL 2'h0
`define HSC_PATT_ONES 2'h1
`define HSC_PATT_PRBS 2'h2
`define HSC_PATT_PDN 2'h3
`define HSC_JA_OFF 2'h0
`define HSC_JA_RX_BROAD 2'h1
`define HSC_JA_RX_NARROW 2'h2
`define HSC_JA_TX 2'h3
`define HSC_FIFO_DEPTH_BROAD 8'h40
`define HSC_FIFO_DEPTH_NARROW 8'h80
`define HSC_FIFO_DEPTH_NONE 8'h00
`define HSC_GAIN_LOW_DB 5'h00
`define HSC_GAIN_HIGH_DB 5'h1a
`define HSC_LP_NONE 2'h0
`define HSC_LP_ANALOG 2'h1
`define HSC_LP_DIGITAL 2'h2
`define HSC_LP_REMOTE 2'h3
`define HSC_SYNC_STAGES 2
`endif

// *** core/hsc_pkg.sv ***
/*
 * types for the hardware strap configuration decoder.
 * assumes nothing beyond a systemverilog compiler.
 */
package hsc_pkg;
    typedef enum logic [1:0] {HSC_TXP_NORMAL, HSC_TXP_ALL_ONES, HSC_TXP_PRBS, HSC_TXP_POWER_DOWN} hsc_tx_pattern_e;
    typedef enum logic [1:0] {HSC_LB_NONE, HSC_LB_ANALOG, HSC_LB_DIGITAL, HSC_LB_REMOTE} hsc_loopback_e;
    typedef enum logic [1:0] {HSC_JA_DISABLED, HSC_JA_RX_BROAD, HSC_JA_RX_NARROW, HSC_JA_TX} hsc_ja_mode_e;
endpackage : hsc_pkg

// *** core/hsc_sync.sv ***
/*
 * two flip-flop synchroniser for one strap level.
 * assumes the strap is static or slowly changing; reset clears both stages.
 */
`timescale 1ns/100ps
`include "hsc_defines.svh"
module hsc_sync (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    hsc_sync_if.sync port_in
);
    logic [`HSC_SYNC_STAGES-1:0] stage;
    // first stage feeds only the second
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            stage <= '0;
        end else begin
            stage <= {stage[0], port_in.raw};
        end
    end
    assign port_in.clean = stage[`HSC_SYNC_STAGES-1];
endmodule : hsc_sync

// *** core/hsc_sync_if.sv ***
/*
 * carries one raw strap bit into a synchroniser and the clean level back.
 * assumes the clock and reset of the decoder.
 */
`timescale 1ns/100ps
interface hsc_sync_if;
    logic raw;
    logic clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : hsc_sync_if

// *** verification/hsc_decode_asserts.sv ***
/* checker: decoder outputs against strap levels.
   assumes outputs follow straps three edges later. */
`timescale 1ns/100ps
module hsc_decode_asserts (
    input logic clock_in,
    input logic sys_rst_in,
    input logic [3:0] tx_pattern_select_in,
    input logic [1:0] jitter_atten_select_in,
    input logic [1:0] rx_monitor_gain_select_in,
    input logic [3:0] loopback_select_in,
    input logic tx_driver_hiz_in,
    input logic rx_clock_edge_select_in,
    input logic [1:0] rx_power_down_in,
    input hsc_pkg::hsc_tx_pattern_e tx_pattern_ch0_out,
    input logic [7:0] ja_fifo_depth_out,
    input logic [9:0] rx_monitor_gain_db_out,
    input hsc_pkg::hsc_loopback_e loopback_ch1_out,
    input logic [1:0] lb_inband_out,
    input logic [1:0] tx_driver_enable_out,
    input logic rx_clock_falling_out,
    input logic [1:0] rx_power_down_out
);
    import hsc_pkg::*;
    logic [1:0] up;
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);
    // edges since reset, so $past never looks into reset
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            up <= 2'h0;
        end else if (up != 2'h3) begin
            up <= up + 2'h1;
        end
    end
    AST_PATT: assert property (up == 2'h3 |-> tx_pattern_ch0_out == $past(tx_pattern_select_in[1:0], 3))
        else $error("pattern wrong");
    AST_DEPTH: assert property (up == 2'h3 |-> ja_fifo_depth_out == ($past(jitter_atten_select_in, 3) == 2'h1 ?
        8'h40 : $past(jitter_atten_select_in, 3) == 2'h2 ? 8'h80 : 8'h00)) else $error("depth wrong");
    AST_GAIN: assert property (up == 2'h3 |-> rx_monitor_gain_db_out ==
        {{5{$past(rx_monitor_gain_select_in[1], 3)}} & 5'h1a, {5{$past(rx_monitor_gain_select_in[0], 3)}} & 5'h1a})
        else $error("gain wrong");
    AST_LB: assert property (up != 2'h0 |-> ##3 loopback_ch1_out == $past(loopback_select_in[3:2], 3))
        else $error("loopback wrong");
    AST_INBAND: assert property (lb_inband_out == 2'h0) else $error("inband set");
    AST_HIZ: assert property (up == 2'h3 |-> tx_driver_enable_out == {2{~$past(tx_driver_hiz_in, 3)}})
        else $error("driver enable wrong");
    AST_EDGE: assert property (up == 2'h3 && $rose(rx_clock_edge_select_in) |-> ##3 rx_clock_falling_out)
        else $error("edge select wrong");
    AST_RPD: assert property (up == 2'h3 |-> rx_power_down_out == $past(rx_power_down_in, 3))
        else $error("power down wrong");
endmodule : hsc_decode_asserts
bind hsc_decode hsc_decode_asserts chk_u (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .tx_pattern_select_in(tx_pattern_select_in),
    .jitter_atten_select_in(jitter_atten_select_in),
    .rx_monitor_gain_select_in(rx_monitor_gain_select_in),
    .loopback_select_in(loopback_select_in),
    .tx_driver_hiz_in(tx_driver_hiz_in),
    .rx_clock_edge_select_in(rx_clock_edge_select_in),
    .rx_power_down_in(rx_power_down_in),
    .tx_pattern_ch0_out(tx_pattern_ch0_out),
    .ja_fifo_depth_out(ja_fifo_depth_out),
    .rx_monitor_gain_db_out(rx_monitor_gain_db_out),
    .loopback_ch1_out(loopback_ch1_out),
    .lb_inband_out(lb_inband_out),
    .tx_driver_enable_out(tx_driver_enable_out),
    .rx_clock_falling_out(rx_clock_falling_out),
    .rx_power_down_out(rx_power_down_out)
);

// *** verification/hsc_strap_board.sv ***
/* board straps: levels a controller sets and holds.
   assumes the bench names the levels it wants. */
`timescale 1ns/100ps
module hsc_strap_board (
    input logic clock_in,
    input logic [15:0] want_in,
    output logic [15:0] strap_out
);
    // levels start low, then move just after an edge and hold
    initial strap_out = 16'h0000;
    always @(posedge clock_in) begin
        strap_out <= want_in;
    end
endmodule : hsc_strap_board

// *** verification/test_hsc_decode.sv ***
/* self-checking bench for the strap decoder.
   assumes three-edge latency and the decoder reset values. */
`timescale 1ns/100ps
module test_hsc_decode;
    import hsc_pkg::*;
    logic clock_in, sys_rst_in;
    logic [15:0] want_in, strap_out;
    logic [3:0] tx_pattern_select_in, loopback_select_in;
    logic [1:0] jitter_atten_select_in, rx_monitor_gain_select_in, rx_power_down_in;
    logic tx_driver_hiz_in, rx_clock_edge_select_in, ja_enable_out, ja_in_rx_out, ja_in_tx_out;
    logic ja_narrow_bw_out, rx_clock_falling_out;
    hsc_tx_pattern_e tx_pattern_ch0_out, tx_pattern_ch1_out;
    hsc_ja_mode_e ja_mode_out;
    hsc_loopback_e loopback_ch0_out, loopback_ch1_out;
    logic [1:0] tx_send_normal_out, tx_send_ones_out, tx_send_prbs_out, tx_power_down_out, rx_power_down_out;
    logic [1:0] lb_analog_out, lb_digital_out, lb_remote_out, lb_inband_out, tx_driver_enable_out;
    logic [7:0] ja_fifo_depth_out;
    logic [9:0] rx_monitor_gain_db_out;
    int errors, checked;
    assign {rx_power_down_in, rx_clock_edge_select_in, tx_driver_hiz_in, loopback_select_in,
        rx_monitor_gain_select_in, jitter_atten_select_in, tx_pattern_select_in} = strap_out;
    hsc_strap_board board_u (
        .clock_in(clock_in),
        .want_in(want_in),
        .strap_out(strap_out)
    );
    hsc_decode dut_u (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .tx_pattern_select_in(tx_pattern_select_in),
        .jitter_atten_select_in(jitter_atten_select_in),
        .rx_monitor_gain_select_in(rx_monitor_gain_select_in),
        .loopback_select_in(loopback_select_in),
        .tx_driver_hiz_in(tx_driver_hiz_in),
        .rx_clock_edge_select_in(rx_clock_edge_select_in),
        .rx_power_down_in(rx_power_down_in),
        .tx_pattern_ch0_out(tx_pattern_ch0_out),
        .tx_pattern_ch1_out(tx_pattern_ch1_out),
        .tx_send_normal_out(tx_send_normal_out),
        .tx_send_ones_out(tx_send_ones_out),
        .tx_send_prbs_out(tx_send_prbs_out),
        .tx_power_down_out(tx_power_down_out),
        .ja_mode_out(ja_mode_out),
        .ja_enable_out(ja_enable_out),
        .ja_in_rx_out(ja_in_rx_out),
        .ja_in_tx_out(ja_in_tx_out),
        .ja_narrow_bw_out(ja_narrow_bw_out),
        .ja_fifo_depth_out(ja_fifo_depth_out),
        .rx_monitor_gain_db_out(rx_monitor_gain_db_out),
        .loopback_ch0_out(loopback_ch0_out),
        .loopback_ch1_out(loopback_ch1_out),
        .lb_analog_out(lb_analog_out),
        .lb_digital_out(lb_digital_out),
        .lb_remote_out(lb_remote_out),
        .lb_inband_out(lb_inband_out),
        .tx_driver_enable_out(tx_driver_enable_out),
        .rx_clock_falling_out(rx_clock_falling_out),
        .rx_power_down_out(rx_power_down_out)
    );
    // 50 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    // one compare, counted
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // one-hot flags per code, channel pairs
    function automatic logic [7:0] hot(input logic [3:0] c);
        for (int k = 0; k < 4; k++) begin
            hot[2*k+:2] = {c[3:2] == 2'(k), c[1:0] == 2'(k)};
        end
    endfunction : hot
    // set straps, let them settle, check every output
    task automatic apply(input logic [15:0] v);
        logic [1:0] j;
        logic [7:0] h;
        j = v[5:4];
        h = hot(v[11:8]);
        @(posedge clock_in);
        want_in <= v;
        repeat (5) @(posedge clock_in);
        #1;
        cmp({tx_pattern_ch1_out, tx_pattern_ch0_out}, v[3:0]);
        cmp({tx_power_down_out, tx_send_prbs_out, tx_send_ones_out, tx_send_normal_out}, hot(v[3:0]));
        cmp({ja_mode_out, ja_enable_out, ja_in_rx_out, ja_in_tx_out}, {j, j != 2'h0, j == 2'h1 || j == 2'h2, j == 2'h3});
        cmp({ja_narrow_bw_out, ja_fifo_depth_out}, {j == 2'h2, j == 2'h1 ? 8'h40 : j == 2'h2 ? 8'h80 : 8'h00});
        cmp(rx_monitor_gain_db_out, {{5{v[7]}} & 5'h1a, {5{v[6]}} & 5'h1a});
        cmp({loopback_ch1_out, loopback_ch0_out, lb_remote_out, lb_digital_out, lb_analog_out}, {v[11:8], h[7:2]});
        cmp(lb_inband_out, 2'h0);
        cmp({tx_driver_enable_out, rx_clock_falling_out, rx_power_down_out}, {~v[12], ~v[12], v[13], v[15:14]});
    endtask : apply
    // counts, verdict, end of run
    task automatic conclude;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    // cut a hang short
    initial begin
        repeat (1000) @(posedge clock_in);
        errors++;
        conclude();
    end
    // every code of every field, random mixes, a burst, a second reset
    initial begin
        errors = 0;
        checked = 0;
        want_in = 16'h0000;
        sys_rst_in = 1'b1;
        void'($urandom(32324));
        repeat (4) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apply({2'(i), i[0], i[1], {6{2'(i)}}});
        end
        repeat (20) apply(16'($urandom));
        repeat (12) begin
            @(posedge clock_in);
            want_in <= 16'($urandom);
        end
        apply(16'h5a5a);
        @(posedge clock_in);
        sys_rst_in <= 1'b1;
        @(posedge clock_in);
        #1;
        cmp({tx_send_normal_out, tx_driver_enable_out, ja_fifo_depth_out, rx_monitor_gain_db_out}, 22'h300000);
        @(posedge clock_in);
        sys_rst_in <= 1'b0;
        apply(16'hffff);
        conclude();
    end
endmodule : test_hsc_decode
